// ### verilog/vitc_cfg.svh
`ifndef VITC_CFG_SVH
`define VITC_CFG_SVH
// register byte addresses
`define VITC_ADDR_FORMAT   8'h00
`define VITC_ADDR_SERPAR   8'h04
`define VITC_ADDR_STATUS   8'h08
// video_input_format bit positions
`define VITC_F_DEINT       4
`define VITC_F_VS_POL      5
`define VITC_F_HS_POL      6
`define VITC_F_VACT_POL    7
`define VITC_F_RISE_SEL    8
`define VITC_F_BUF_LO      9
`define VITC_F_BUF_HI      10
`define VITC_F_TILE        11
`define VITC_F_TVS_POL     12
`define VITC_F_THS_POL     13
`define VITC_F_VMI_EN      14
`define VITC_F_TV_EN       15
`define VITC_F_GENLOCK     16
`define VITC_F_NO_VGA      17
`define VITC_F_GL_SRC      18
`define VITC_F_DE_SEL      19
`define VITC_F_HDEC        20
`define VITC_F_VDEC        21
`define VITC_F_PLAIN       22
`define VITC_F_VREF_FL     23
`define VITC_F_VACT_FL     24
`define VITC_F_MSB         24
// serial_parallel_port_control bit positions
`define VITC_S_HOST_EN     0
`define VITC_S_CS_N        1
`define VITC_S_STB_A       2
`define VITC_S_STB_B       3
`define VITC_S_SYNC_OE     29
// status register bit positions
`define VITC_T_EVEN        0
`define VITC_T_CFG_OK      1
`define VITC_T_ROM         2
// reset values
`define VITC_FORMAT_RST    25'h0000000
`define VITC_SERPAR_RST    4'h0
`endif

// ### verilog/vitc_pkg.sv
package vitc_pkg;
	// one rgb888 pixel headed for the encoder
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} vitc_pixel_type;
	// clock that the remaining video logic runs on
	typedef enum logic [1:0] {
		VITC_CLK_PLL = 2'h0,
		VITC_CLK_VMI = 2'h1,
		VITC_CLK_TV  = 2'h2
	} vitc_clk_sel_type;
	// origin of the video timing
	typedef enum logic [1:0] {
		VITC_TIM_VGA = 2'h0,
		VITC_TIM_VMI = 2'h1,
		VITC_TIM_TV  = 2'h2
	} vitc_tim_sel_type;
	// raw syncs from outside, pre-polarity
	typedef struct packed {
		logic vsync;
		logic hsync;
	} vitc_sync_type;
endpackage

// ### verilog/vitc_port.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "vitc_cfg.svh"
// Functional notes
// - format bit 7 inverts vmi active qualifier
// - blue/green half on bus, edge by bit 8
// - red/green half on other edge
// - bits 10:9 pick single/double/triple buffering
// - bit 11 picks linear or tiled buffer
// - bits 12/13 invert encoder vsync/hsync
// - bits 14/15 enable vmi and tv sides
// - bit 16 picks pll or genlock clock
// - bit 17 picks vga or external timing
// - bit 18 picks vmi or encoder genlock
// - bit 19 gates output with display enable
// - bits 20/21 enable h/v decimation
// - bit 22 selects plain bus ordering
// - bits 23/24 enable flushes, rest reserved
// - vsync trailing edge, hsync active means even
// - driver enable low while vmi owns pins
// - software enables sync drivers, vmi drives always
// - bit 0 enables host port, cs held off
// - bits 1..3 drive chip select and strobes
// - bits 5/6 invert vmi vsync/hsync
// - bit 4 weaves two fields per frame
module vitc_port (
	input  wire logic                      ref_clk,        // 250 MHz core clock
	input  wire logic                      sys_rst,        // sync reset, high
	input  wire logic [7:0]                reg_addr,       // register byte address
	input  wire logic [31:0]               reg_wdata,      // write data
	input  wire logic                      reg_wr,         // write strobe
	input  wire logic                      reg_rd,         // read strobe
	output logic      [31:0]               reg_rdata,      // read data, cycle after strobe
	input  wire logic                      vmi_pixclk,     // vmi pixel clock pin
	input  wire vitc_pkg::vitc_sync_type   vmi_sync,       // vmi syncs pin
	input  wire logic                      vmi_vactive,    // vmi active video pin
	input  wire logic                      encoder_clock_input, // encoder clock pin
	input  wire vitc_pkg::vitc_sync_type   tv_sync,        // encoder syncs pin
	input  wire vitc_pkg::vitc_sync_type   vga_sync,       // internal vga syncs
	input  wire logic                      vga_blank_n,    // internal vga blank
	input  wire logic                      display_ena,    // internal display enable
	input  wire vitc_pkg::vitc_pixel_type  pix_in,         // pixel for the encoder
	input  wire logic                      pix_valid,      // pixel strobe
	input  wire logic                      rom_access,     // rom owns shared pins
	output logic      [11:0]               tv_data_rise,   // bus half for rising edge
	output logic      [11:0]               tv_data_fall,   // bus half for falling edge
	output logic                           tv_blank_n,     // blank to encoder
	output vitc_pkg::vitc_sync_type        timing_sync,    // chosen timing, active high
	output vitc_pkg::vitc_clk_sel_type     video_clk_sel,  // clock mux select
	output logic                           vmi_active,     // qualifier, active high
	output logic                           field_even,     // last field parity
	output logic                           frame_done,     // pulse per stored frame
	output logic                           vref_flush,     // flush pulse on vref
	output logic                           vact_flush,     // flush pulse on vact
	output logic      [1:0]                buf_mode,       // 0 single,1 double,2 triple
	output logic                           buf_tiled,      // tiled addressing
	output logic                           hdec_en,        // horizontal decimation
	output logic                           vdec_en,        // vertical decimation
	output logic                           vmi_cs_n,       // host port chip select
	output logic                           vmi_stb_a_n,    // data strobe or read strobe
	output logic                           vmi_stb_b_n,    // read/write or write strobe
	output logic                           gpio_drv_oe,    // gpio0 shared-pin driver enable
	output logic                           gpio_sync_oe    // gpio1 sync driver enable
);
	// programmable state
	logic [`VITC_F_MSB:0] fmt_q;      // video_input_format
	logic [3:0]           spp_q;      // serial_parallel_port_control low bits
	logic                 sync_oe_q;  // serial_parallel_port_control gpio1 bit
	logic [31:0]          rdata_q;    // registered read data

	// two-stage synchronisers for every pin that arrives from outside
	logic [6:0] s1_q;                 // first stage, read only by second
	logic [6:0] s2_q;                 // second stage, safe to use
	logic       pclk_d1_q;            // pixel clock history

	// derived state
	logic       vs_lat_q;             // vmi vsync at last pixel clock edge
	logic       vact_lat_q;           // vmi active at last pixel clock edge
	logic       field_phase_q;        // weave half-frame tracker
	logic       even_q;
	logic       frame_q;
	logic       vref_q;
	logic       vact_fl_q;
	logic [11:0] rise_q;
	logic [11:0] fall_q;
	logic       blank_q;
	vitc_pkg::vitc_sync_type     tsync_q;
	vitc_pkg::vitc_clk_sel_type  clk_sel_q;
	logic       active_q;
	logic       cs_q;
	logic       stb_a_q;
	logic       stb_b_q;
	logic       drv_oe_q;

	// scrambled halves keep the encoder's split of colour bits
	function automatic logic [11:0] half_bg(input vitc_pkg::vitc_pixel_type p,
			input logic plain);
		half_bg = plain ? {p.b[0], p.b[1], p.b[2], p.b[3], p.b[4], p.b[5], p.b[6],
			p.b[7], p.g[0], p.g[1], p.g[2], p.g[3]}
			: {p.g[4:2], p.b[7:3], p.g[0], p.b[2:0]};
	endfunction
	function automatic logic [11:0] half_rg(input vitc_pkg::vitc_pixel_type p,
			input logic plain);
		half_rg = plain ? {p.g[4], p.g[5], p.g[6], p.g[7], p.r[0], p.r[1], p.r[2],
			p.r[3], p.r[4], p.r[5], p.r[6], p.r[7]}
			: {p.r[7:3], p.g[7:5], p.r[2:0], p.g[1]};
	endfunction

	// pin synchroniser order
	localparam int SI_PCLK = 0;
	localparam int SI_VVS  = 1;
	localparam int SI_VHS  = 2;
	localparam int SI_VACT = 3;
	localparam int SI_TVS  = 4;
	localparam int SI_THS  = 5;
	localparam int SI_TCLK = 6;

	// address decode
	wire sel_fmt  = (reg_addr == `VITC_ADDR_FORMAT);
	wire sel_spp  = (reg_addr == `VITC_ADDR_SERPAR);
	wire sel_stat = (reg_addr == `VITC_ADDR_STATUS);
	wire wr_fmt   = reg_wr & sel_fmt;
	wire wr_spp   = reg_wr & sel_spp;

	// polarity-corrected syncs, all active high from here on
	wire vmi_vs   = s2_q[SI_VVS] ^ fmt_q[`VITC_F_VS_POL];
	wire vmi_hs   = s2_q[SI_VHS] ^ fmt_q[`VITC_F_HS_POL];
	wire vmi_va   = s2_q[SI_VACT] ^ fmt_q[`VITC_F_VACT_POL];
	wire tv_vs    = s2_q[SI_TVS] ^ fmt_q[`VITC_F_TVS_POL];
	wire tv_hs    = s2_q[SI_THS] ^ fmt_q[`VITC_F_THS_POL];
	// pixel clock rising edge: field detection takes the syncs only there
	wire pclk_rise = s2_q[SI_PCLK] & ~pclk_d1_q;
	wire vmi_on    = fmt_q[`VITC_F_VMI_EN];
	wire tv_on     = fmt_q[`VITC_F_TV_EN];
	// vsync trailing edge seen at a pixel clock edge
	wire vs_trail  = vmi_on & pclk_rise & vs_lat_q & ~vmi_vs;
	wire va_lead   = vmi_on & pclk_rise & ~vact_lat_q & vmi_va;
	wire weave     = fmt_q[`VITC_F_DEINT];
	// frame complete: every field, or every second field when weaving
	wire frame_evt = vs_trail & (~weave | field_phase_q);

	// clock and timing source
	wire gl_en    = fmt_q[`VITC_F_GENLOCK];
	wire gl_tv    = fmt_q[`VITC_F_GL_SRC];
	wire no_vga   = fmt_q[`VITC_F_NO_VGA];
	wire vitc_pkg::vitc_clk_sel_type clk_sel_d = !gl_en ? vitc_pkg::VITC_CLK_PLL
		: (gl_tv ? vitc_pkg::VITC_CLK_TV : vitc_pkg::VITC_CLK_VMI);
	// struct order is {vsync, hsync}, so a plain concatenation fills it
	wire vitc_pkg::vitc_sync_type ext_sync = gl_tv ? {tv_vs, tv_hs} : {vmi_vs, vmi_hs};
	wire vitc_pkg::vitc_sync_type tsync_d = no_vga ? ext_sync : vga_sync;
	// output gating signal: display enable or vga blank
	wire gate_d   = fmt_q[`VITC_F_DE_SEL] ? display_ena : vga_blank_n;
	// status only: flags combinations outside the supported set
	wire cfg_ok   = (gl_en == no_vga) ? (!gl_en | gl_tv) : (gl_en & !gl_tv);
	wire plain    = fmt_q[`VITC_F_PLAIN];
	wire [11:0] bg_half = half_bg(pix_in, plain);
	wire [11:0] rg_half = half_rg(pix_in, plain);

	// read mux, reserved and unmapped bits read zero
	wire [31:0] spp_rd  = {2'h0, sync_oe_q, 25'h0, spp_q};
	wire [31:0] stat_rd = {29'h0, drv_oe_q, cfg_ok, even_q};
	wire [31:0] rd_d    = sel_fmt ? {7'h00, fmt_q} : sel_spp ? spp_rd
		: sel_stat ? stat_rd : 32'h00000000;

	// register writes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fmt_q     <= `VITC_FORMAT_RST;
			spp_q     <= `VITC_SERPAR_RST;
			sync_oe_q <= 1'b0;
		end else begin
			if (wr_fmt) begin
				fmt_q <= reg_wdata[`VITC_F_MSB:0];
			end
			if (wr_spp) begin
				spp_q     <= reg_wdata[`VITC_S_STB_B:`VITC_S_HOST_EN];
				sync_oe_q <= reg_wdata[`VITC_S_SYNC_OE];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= reg_rd ? rd_d : 32'h00000000;
		end
	end

	// synchronisers; stage one feeds stage two and nothing else
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s1_q      <= 7'h00;
			s2_q      <= 7'h00;
			pclk_d1_q <= 1'b0;
		end else begin
			s1_q      <= {encoder_clock_input, tv_sync.hsync, tv_sync.vsync, vmi_vactive,
				vmi_sync.hsync, vmi_sync.vsync, vmi_pixclk};
			s2_q      <= s1_q;
			pclk_d1_q <= s2_q[SI_PCLK];
		end
	end

	// field detection and flush events on pixel clock edges
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vs_lat_q      <= 1'b0;
			vact_lat_q    <= 1'b0;
			field_phase_q <= 1'b0;
			even_q        <= 1'b0;
			frame_q       <= 1'b0;
			vref_q        <= 1'b0;
			vact_fl_q     <= 1'b0;
		end else begin
			if (pclk_rise) begin
				vs_lat_q   <= vmi_vs;
				vact_lat_q <= vmi_va;
			end
			if (vs_trail) begin
				even_q        <= vmi_hs;
				field_phase_q <= weave & ~field_phase_q;
			end
			frame_q   <= frame_evt;
			vref_q    <= vs_trail & fmt_q[`VITC_F_VREF_FL];
			vact_fl_q <= va_lead & fmt_q[`VITC_F_VACT_FL];
		end
	end

	// encoder bus: bit 8 swaps which half goes on which edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rise_q  <= 12'h000;
			fall_q  <= 12'h000;
			blank_q <= 1'b0;
		end else begin
			if (!tv_on) begin
				rise_q <= 12'h000;
				fall_q <= 12'h000;
			end else if (pix_valid) begin
				rise_q <= fmt_q[`VITC_F_RISE_SEL] ? rg_half : bg_half;
				fall_q <= fmt_q[`VITC_F_RISE_SEL] ? bg_half : rg_half;
			end
			blank_q <= tv_on & gate_d;
		end
	end

	// timing selection and mode outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tsync_q   <= '{vsync: 1'b0, hsync: 1'b0};
			clk_sel_q <= vitc_pkg::VITC_CLK_PLL;
			active_q  <= 1'b0;
		end else begin
			tsync_q   <= tsync_d;
			clk_sel_q <= clk_sel_d;
			active_q  <= vmi_on & vmi_va;
		end
	end

	// host port pins; cs forced off while the port is disabled
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cs_q     <= 1'b1;
			stb_a_q  <= 1'b1;
			stb_b_q  <= 1'b1;
			drv_oe_q <= 1'b0;
		end else begin
			cs_q     <= ~spp_q[`VITC_S_HOST_EN] | spp_q[`VITC_S_CS_N];
			stb_a_q  <= spp_q[`VITC_S_STB_A];
			stb_b_q  <= spp_q[`VITC_S_STB_B];
			drv_oe_q <= rom_access;
		end
	end

	// mode fields drive the capture engine straight from the register
	assign buf_mode      = fmt_q[`VITC_F_BUF_HI:`VITC_F_BUF_LO];
	assign buf_tiled     = fmt_q[`VITC_F_TILE];
	assign hdec_en       = fmt_q[`VITC_F_HDEC];
	assign vdec_en       = fmt_q[`VITC_F_VDEC];
	assign reg_rdata     = rdata_q;
	assign tv_data_rise  = rise_q;
	assign tv_data_fall  = fall_q;
	assign tv_blank_n    = blank_q;
	assign timing_sync   = tsync_q;
	assign video_clk_sel = clk_sel_q;
	assign vmi_active    = active_q;
	assign field_even    = even_q;
	assign frame_done    = frame_q;
	assign vref_flush    = vref_q;
	assign vact_flush    = vact_fl_q;
	assign vmi_cs_n      = cs_q;
	assign vmi_stb_a_n   = stb_a_q;
	assign vmi_stb_b_n   = stb_b_q;
	assign gpio_drv_oe   = drv_oe_q;
	assign gpio_sync_oe  = sync_oe_q;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_vact_pol;
		vmi_on |=> (vmi_active == $past(vmi_va));
	endproperty
	a_vact_pol: assert property (p_vact_pol) else $error("active qualifier wrong");
	property p_bus_order;
		(tv_on && pix_valid && !fmt_q[`VITC_F_RISE_SEL])
			|=> (tv_data_rise == $past(bg_half)) && (tv_data_fall == $past(rg_half));
	endproperty
	a_bus_order: assert property (p_bus_order) else $error("bus half order wrong");
	property p_bus_swap;
		(tv_on && pix_valid && fmt_q[`VITC_F_RISE_SEL]) |=> tv_data_rise == $past(rg_half);
	endproperty
	a_bus_swap: assert property (p_bus_swap) else $error("edge swap wrong");
	property p_buf_mode;
		wr_fmt |=> buf_mode == $past(reg_wdata[`VITC_F_BUF_HI:`VITC_F_BUF_LO]);
	endproperty
	a_buf_mode: assert property (p_buf_mode) else $error("buffer mode not stored");
	property p_tv_off;
		!tv_on ##1 !tv_on |-> (tv_data_rise == 12'h000) && !tv_blank_n;
	endproperty
	a_tv_off: assert property (p_tv_off) else $error("tv output while off");
	property p_clk_sel;
		!gl_en ##1 !gl_en |-> video_clk_sel == vitc_pkg::VITC_CLK_PLL;
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
	property p_field;
		vs_trail |=> field_even == $past(vmi_hs);
	endproperty
	a_field: assert property (p_field) else $error("field parity wrong");
	property p_drv_oe;
		rom_access [*2] |-> gpio_drv_oe;
	endproperty
	a_drv_oe: assert property (p_drv_oe) else $error("driver enable wrong");
	property p_cs_off;
		!spp_q[`VITC_S_HOST_EN] |=> vmi_cs_n;
	endproperty
	a_cs_off: assert property (p_cs_off) else $error("chip select not held off");
	property p_weave;
		(weave && vs_trail && !field_phase_q) |=> !frame_done;
	endproperty
	a_weave: assert property (p_weave) else $error("weave frame early");
	property p_rd_zero;
		!reg_rd |=> reg_rdata == 32'h00000000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");

	c_field_even: cover property (vs_trail && vmi_hs);
	c_weave_frame: cover property (weave && frame_evt);
	c_tv_master: cover property (gl_en && gl_tv && no_vga && tv_on);
	c_host_cs: cover property (spp_q[`VITC_S_HOST_EN] && !vmi_cs_n);
endmodule // vitc_port

// ### verification/vitc_vmi_model.sv
`timescale 1ns/100ps
// behavioural video decoder on the far side of the vmi pins
module vitc_vmi_model (
	output logic                    pixclk,  // free-running pixel clock
	output vitc_pkg::vitc_sync_type sync,    // raw syncs, programmed polarity
	output logic                    vactive  // raw active qualifier
);
	// a decoder's pixel clock runs free, so it never stands still here
	initial pixclk = 1'b0;
	initial sync = 2'h0;
	initial vactive = 1'b0;
	// 125 ns period, unrelated to the core clock
	always #62.5 pixclk = ~pixclk;
	// park both syncs inactive; inactive raw level equals the polarity bit
	task idle(input logic vp, input logic hp);
		@(negedge pixclk);
		sync = {vp, hp};
	endtask
	// one vsync pulse; hsync held through its trailing edge marks parity
	task field(input logic even, input logic vp, input logic hp);
		@(negedge pixclk);
		sync.vsync = ~vp;
		sync.hsync = even ? ~hp : hp;
		repeat (3) @(negedge pixclk);
		sync.vsync = vp; // changed off the rising edge so it stays stable across it
		repeat (2) @(negedge pixclk);
		sync.hsync = hp;
		@(negedge pixclk);
	endtask
	// qualifier level, kept driven continuously
	task act(input logic v);
		@(negedge pixclk);
		vactive = v;
	endtask
endmodule // vitc_vmi_model

// ### verification/test_video_in_tv_out_port_config.sv
`timescale 1ns/100ps
module test_video_in_tv_out_port_config;
	logic                       ref_clk = 1'b0;  // core clock
	logic                       sys_rst = 1'b1;  // held for four cycles
	logic [7:0]                 reg_addr = 8'h00;
	logic [31:0]                reg_wdata = 32'h0;
	logic                       reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0]                reg_rdata;
	logic                       vmi_pixclk, vmi_vactive, enc_clk = 1'b0;
	vitc_pkg::vitc_sync_type    vmi_sync, timing_sync, tv_sync = 2'h0, vga_sync = 2'h0;
	logic                       vga_blank_n = 1'b1, display_ena = 1'b0;
	logic                       pix_valid = 1'b0, rom_access = 1'b0;
	vitc_pkg::vitc_pixel_type   pix_in = 24'h0;
	logic [11:0]                tv_data_rise, tv_data_fall;
	logic                       tv_blank_n, vmi_active, field_even, frame_done;
	logic                       vref_flush, vact_flush, buf_tiled, hdec_en, vdec_en;
	logic                       vmi_cs_n, vmi_stb_a_n, vmi_stb_b_n, gpio_drv_oe, gpio_sync_oe;
	vitc_pkg::vitc_clk_sel_type video_clk_sel;
	logic [1:0]                 buf_mode;
	int                         num_errors = 0, tests_run = 0, n_frame = 0, n_vref = 0;
	int                         n_vact = 0;          // vact flush pulses seen
	logic [31:0]                seed = 32'h00016d6f; // fixed seed, repeatable runs
	logic [31:0]                fmt = 32'h0;         // mirror of the format register
	logic [4:0]                 exp_q = 5'h0;        // expectations for the next edge
	logic                       mon = 1'b0;          // per-cycle monitor armed

	vitc_port vitc_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.vmi_pixclk(vmi_pixclk), .vmi_sync(vmi_sync), .vmi_vactive(vmi_vactive),
		.encoder_clock_input(enc_clk), .tv_sync(tv_sync), .vga_sync(vga_sync),
		.vga_blank_n(vga_blank_n), .display_ena(display_ena), .pix_in(pix_in),
		.pix_valid(pix_valid), .rom_access(rom_access), .tv_data_rise(tv_data_rise),
		.tv_data_fall(tv_data_fall), .tv_blank_n(tv_blank_n), .timing_sync(timing_sync),
		.video_clk_sel(video_clk_sel), .vmi_active(vmi_active), .field_even(field_even),
		.frame_done(frame_done), .vref_flush(vref_flush), .vact_flush(vact_flush),
		.buf_mode(buf_mode), .buf_tiled(buf_tiled), .hdec_en(hdec_en), .vdec_en(vdec_en),
		.vmi_cs_n(vmi_cs_n), .vmi_stb_a_n(vmi_stb_a_n), .vmi_stb_b_n(vmi_stb_b_n),
		.gpio_drv_oe(gpio_drv_oe), .gpio_sync_oe(gpio_sync_oe));
	vitc_vmi_model vitc_vmi_model_i (.pixclk(vmi_pixclk), .sync(vmi_sync),
		.vactive(vmi_vactive));

	always #2 ref_clk = ~ref_clk;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected {rise, fall} halves of one pixel
	function logic [23:0] halves(vitc_pkg::vitc_pixel_type p, logic rs, logic pl);
		logic [11:0] bg, rg;
		bg = {p.g[4:2], p.b[7:3], p.g[0], p.b[2:0]};
		rg = {p.r[7:3], p.g[7:5], p.r[2:0], p.g[1]};
		// plain order mirrors each colour across the bus
		if (pl) for (int i = 0; i < 8; i++) begin
			bg[11-i] = p.b[i];
			rg[7-i] = p.r[i];
			if (i < 4) begin
				bg[3-i] = p.g[i];
				rg[11-i] = p.g[4+i];
			end
		end
		return rs ? {rg, bg} : {bg, rg};
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task test_done;
		if (num_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// the mirror changes at the edge that takes the write, like the register
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		if (a == 8'h00) fmt <= d;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task pixchk;
		logic [23:0] e;
		logic [31:0] r;
		vitc_pkg::vitc_pixel_type p;
		r = rnd();
		p = r[23:0];
		@(posedge ref_clk);
		pix_in <= p;
		pix_valid <= 1'b1;
		@(posedge ref_clk);
		pix_valid <= 1'b0;
		#1 e = fmt[15] ? halves(p, fmt[8], fmt[22]) : 24'h0;
		chk("tv_data_rise", e[23:12], tv_data_rise);
		chk("tv_data_fall", e[11:0], tv_data_fall);
	endtask

	// random side inputs; outputs read before this edge's updates land
	always @(posedge ref_clk) begin
		logic [31:0] r;
		r = rnd();
		vga_blank_n <= r[0];
		display_ena <= r[1];
		rom_access <= r[2];
		vga_sync <= r[4:3];
		enc_clk <= r[5];
		exp_q <= {fmt[17], fmt[15] & (fmt[19] ? display_ena : vga_blank_n), rom_access, vga_sync};
		if (mon) begin
			chk("tv_blank_n", exp_q[3], tv_blank_n);
			chk("gpio_drv_oe", exp_q[2], gpio_drv_oe);
			if (!exp_q[4]) chk("timing_sync", exp_q[1:0], timing_sync);
		end
	end
	// pulse counters
	always @(posedge ref_clk) begin
		if (frame_done === 1'b1) n_frame++;
		if (vref_flush === 1'b1) n_vref++;
		if (vact_flush === 1'b1) n_vact++;
	end
	// whole run is under twenty microseconds; this is ten times that or more
	initial begin
		#200000;
		num_errors++;
		test_done;
	end

	initial begin
		logic [31:0] d, v;
		logic e;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		mon <= 1'b1;
		rd(8'h00, d);
		chk("format_rst", 32'h0, d);
		rd(8'h04, d);
		chk("serpar_rst", 32'h0, d);
		rd(8'h0c, d);
		chk("unmapped", 32'h0, d);
		chk("vmi_cs_n", 32'h1, vmi_cs_n);
		// field outputs, reserved bits and an ignored unmapped write
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 32'hffffffff : rnd();
			v[17] = v[16] & v[18];
			wr(8'h00, v);
			wr(8'h0c, rnd());
			rd(8'h00, d);
			chk("format", v & 32'h01ffffff, d);
			chk("buf_mode", v[10:9], buf_mode);
			chk("buf_tiled", v[11], buf_tiled);
			chk("hdec_en", v[20], hdec_en);
			chk("vdec_en", v[21], vdec_en);
		end
		// clock selection over genlock enable and source
		for (int k = 0; k < 4; k++) begin
			v = 32'h00008000;
			v[16] = k[0];
			v[17] = k[0] & k[1];
			v[18] = k[1];
			wr(8'h00, v);
			repeat (2) @(posedge ref_clk);
			#1 chk("video_clk_sel", !k[0] ? 2'h0 : (k[1] ? 2'h2 : 2'h1), video_clk_sel);
			rd(8'h08, d);
			chk("cfg_ok", 32'h1, d[1]);
		end
		// encoder timing with both polarity settings
		for (int k = 0; k < 16; k++) begin
			v = 32'h00078000;
			v[13:12] = k[3:2];
			@(posedge ref_clk);
			tv_sync <= k[1:0];
			wr(8'h00, v);
			repeat (8) @(posedge ref_clk);
			#1 chk("tv_timing", {k[1] ^ k[2], k[0] ^ k[3]}, timing_sync);
		end
		// every edge choice and bus order, then output disabled
		for (int k = 0; k < 10; k++) begin
			v = 32'h0;
			v[8] = k[0];
			v[22] = k[1];
			v[15] = ~k[3];
			wr(8'h00, v);
			pixchk;
			pixchk;
		end
		// blank source both ways, watched by the monitor
		wr(8'h00, 32'h00088000);
		repeat (20) @(posedge ref_clk);
		wr(8'h00, 32'h00008000);
		repeat (20) @(posedge ref_clk);
		// host port pins and the gpio1 bit; other bits written at random
		for (int k = 0; k < 32; k++) begin
			v = {2'h0, k[4], 25'h0, k[3:0]};
			wr(8'h04, v | (rnd() & 32'hdffffff0));
			rd(8'h04, d);
			chk("serpar", v, d);
			chk("vmi_cs_n", {31'h0, ~k[0] | k[1]}, vmi_cs_n);
			chk("vmi_stb_a_n", k[2], vmi_stb_a_n);
			chk("vmi_stb_b_n", k[3], vmi_stb_b_n);
			chk("gpio_sync_oe", k[4], gpio_sync_oe);
		end
		// fields: plain polarity without weave, then inverted with weave
		for (int k = 0; k < 2; k++) begin
			vitc_vmi_model_i.idle(k, k);
			v = 32'h00800000;
			v[4] = k;
			v[5] = k;
			v[6] = k;
			wr(8'h00, v); // polarity first, port still off, so no false edge
			repeat (100) @(posedge ref_clk);
			v[14] = 1'b1;
			wr(8'h00, v);
			repeat (100) @(posedge ref_clk);
			n_frame = 0;
			n_vref = 0;
			for (int j = 0; j < 4; j++) begin
				d = rnd();
				e = d[0];
				vitc_vmi_model_i.field(e, k, k);
				repeat (20) @(posedge ref_clk);
				#1 chk("field_even", e, field_even);
			end
			rd(8'h08, d);
			chk("status_even", e, d[0]);
			chk("frames", k ? 2 : 4, n_frame);
			chk("vref_flush", 4, n_vref);
		end
		// active qualifier polarity, then port disabled
		for (int k = 0; k < 4; k++) begin
			vitc_vmi_model_i.act(k[0]);
			v = 32'h01004000;
			v[7] = k[1];
			wr(8'h00, v);
			repeat (100) @(posedge ref_clk);
			#1 chk("vmi_active", k[0] ^ k[1], vmi_active);
			// flip the pin: a flush only when the qualifier goes active
			n_vact = 0;
			vitc_vmi_model_i.act(~k[0]);
			repeat (100) @(posedge ref_clk);
			chk("vact_flush", {31'h0, ~(k[0] ^ k[1])}, n_vact);
			v[14] = 1'b0;
			wr(8'h00, v);
			repeat (100) @(posedge ref_clk);
			#1 chk("vmi_active_off", 32'h0, vmi_active);
		end
		test_done;
	end
endmodule // test_video_in_tv_out_port_config
